// ---- rtl/temp_sensor_register_bank.v ----
// Register bank and two-wire slave of the temperature sensor
`timescale 1ns/1ps
`include "temp_bank_regs.vh"
module temp_sensor_register_bank #(
  parameter [6:0]  DEV_ADDR     = 7'h48,
  parameter [15:0] IDENTITY     = 16'h0A5C,  // Arbitrary identity value
  parameter [15:0] PROG_CYCLES  = `NVM_PROG_CYCLES
) (
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_b_o,
  input  wire        sample_valid_i,
  input  wire [15:0] sample_data_i,
  output reg         conv_enable_o,
  output reg  [2:0]  cycle_period_o,
  output reg         alert_o
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX   = 5'b00010;
  localparam [4:0] ST_ACK  = 5'b00100;
  localparam [4:0] ST_TX   = 5'b01000;
  localparam [4:0] ST_RACK = 5'b10000;
  localparam [15:0] RST_CFG = `RST_CONFIG;

  wire        scl_s;
  wire        sda_s;
  reg         scl_d;
  reg         sda_d;
  reg  [4:0]  state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [2:0]  byte_idx_reg;
  reg  [7:0]  shift_reg;
  reg         rw_reg;
  reg         gc_reg;
  reg         nack_reg;
  reg         tx_lsb_reg;
  reg  [15:0] tx_word_reg;
  reg  [7:0]  ptr_reg;
  reg  [7:0]  data_hi_reg;
  reg  [15:0] wr_data_reg;
  reg         wr_stb_reg;
  reg         rd_stb_reg;
  reg         gc_stb_reg;

  reg  [15:0] measured_reg;
  reg  [9:0]  cfg_reg;
  reg  [15:0] upper_reg;
  reg  [15:0] lower_reg;
  reg         gate_reg;
  reg  [15:0] user_reg [0:3];
  reg  [15:0] cell_reg [0:6];
  reg         high_reg;
  reg         low_reg;
  reg         done_reg;
  reg         busy_reg;
  reg         load_reg;
  reg  [15:0] prog_cnt_reg;
  reg  signed [22:0] acc_reg;
  reg  [6:0]  avg_cnt_reg;
  reg  [15:0] rd_word;
  reg  [15:0] avg_val;
  integer     i;

  sync_two_ff #(.RESET_VAL(1'b1)) u_scl_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (scl_i),
    .sync_o    (scl_s)
  );

  sync_two_ff #(.RESET_VAL(1'b1)) u_sda_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (sda_i),
    .sync_o    (sda_s)
  );

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  wire [1:0] regime     = cfg_reg[`BIT_REGIME_HI-2:`BIT_REGIME_LO-2];
  wire [1:0] avg_sel    = cfg_reg[`BIT_AVG_HI-2:`BIT_AVG_LO-2];
  wire       therm_mode = cfg_reg[`BIT_THERM-2];
  wire       level_high = cfg_reg[`BIT_LEVEL-2];
  wire       pin_src    = cfg_reg[`BIT_PINSRC-2];
  wire [15:0] cfg_view  = {high_reg, low_reg, done_reg, busy_reg, cfg_reg, 2'b00}; // [R17]

  always @* begin
    case (ptr_reg)
      `OFF_MEASURED: rd_word = measured_reg;
      `OFF_CONFIG:   rd_word = cfg_view;
      `OFF_UPPER:    rd_word = upper_reg;
      `OFF_LOWER:    rd_word = lower_reg;
      `OFF_GATE:     rd_word = {gate_reg, busy_reg, 14'h0000};
      `OFF_USER1:    rd_word = user_reg[0];
      `OFF_USER2:    rd_word = user_reg[1];
      `OFF_USER3:    rd_word = user_reg[2];
      `OFF_USER4:    rd_word = user_reg[3];
      `OFF_IDENTITY: rd_word = IDENTITY;
      default:       rd_word = 16'h0000;
    endcase
  end

  // Two-wire slave: address, pointer, then data bytes MSB first
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 3'h0;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
      gc_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      tx_lsb_reg   <= 1'b0;
      tx_word_reg  <= 16'h0000;
      ptr_reg      <= 8'h00;
      data_hi_reg  <= 8'h00;
      wr_data_reg  <= 16'h0000;
      wr_stb_reg   <= 1'b0;
      rd_stb_reg   <= 1'b0;
      gc_stb_reg   <= 1'b0;
      sda_o        <= 1'b0;
      sda_oe_b_o   <= 1'b1;
    end else begin
      scl_d      <= scl_s;
      sda_d      <= sda_s;
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      gc_stb_reg <= 1'b0;
      sda_o      <= 1'b0;
      if (bus_start) begin
        state_reg    <= ST_RX;
        bit_cnt_reg  <= 4'h0;
        byte_idx_reg <= 3'h0;
        sda_oe_b_o   <= 1'b1;
      end else if (bus_stop) begin
        state_reg  <= ST_IDLE;
        sda_oe_b_o <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_b_o <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_ACK;
              sda_oe_b_o  <= 1'b0;
              if (byte_idx_reg == 3'h0) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  gc_reg <= 1'b0;
                  if (shift_reg[0]) begin
                    tx_word_reg <= rd_word; // [R18]
                    rd_stb_reg  <= 1'b1;
                  end
                end else if (shift_reg == {`GC_ADDR, 1'b0}) begin
                  rw_reg <= 1'b0;
                  gc_reg <= 1'b1;
                end else begin
                  state_reg  <= ST_IDLE;
                  sda_oe_b_o <= 1'b1;
                end
              end else if (gc_reg) begin
                if (byte_idx_reg == 3'h1 && shift_reg == `GC_RESET_CMD)
                  gc_stb_reg <= 1'b1; // [R19]
              end else if (byte_idx_reg == 3'h1) begin
                ptr_reg <= shift_reg; // [R18]
              end else if (byte_idx_reg == 3'h2) begin
                data_hi_reg <= shift_reg; // [R18]
              end else if (byte_idx_reg == 3'h3) begin
                wr_data_reg <= {data_hi_reg, shift_reg};
                wr_stb_reg  <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              byte_idx_reg <= (byte_idx_reg == 3'h4) ? 3'h4 : byte_idx_reg + 3'h1;
              if (rw_reg) begin
                state_reg   <= ST_TX;
                shift_reg   <= tx_word_reg[15:8];
                sda_oe_b_o  <= tx_word_reg[15];
                bit_cnt_reg <= 4'h1;
                tx_lsb_reg  <= 1'b0;
              end else begin
                state_reg  <= ST_RX;
                sda_oe_b_o <= 1'b1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                state_reg   <= ST_RACK;
                sda_oe_b_o  <= 1'b1;
                bit_cnt_reg <= 4'h0;
              end else begin
                sda_oe_b_o  <= shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b1};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s;
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg   <= ST_TX;
                tx_lsb_reg  <= ~tx_lsb_reg;
                shift_reg   <= tx_lsb_reg ? tx_word_reg[15:8] : tx_word_reg[7:0]; // [R18]
                sda_oe_b_o  <= tx_lsb_reg ? tx_word_reg[15] : tx_word_reg[7];
                bit_cnt_reg <= 4'h1;
              end
            end
          end
          default: begin
            state_reg  <= ST_IDLE;
            sda_oe_b_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // Block averaging: 1, 8, 32 or 64 results summed, then shifted down
  wire [6:0] avg_target = (avg_sel == 2'b00) ? 7'd1 :
                          (avg_sel == 2'b01) ? 7'd8 :
                          (avg_sel == 2'b10) ? 7'd32 : 7'd64; // [R11]
  wire signed [22:0] acc_sum = acc_reg + {{7{sample_data_i[15]}}, sample_data_i};
  wire conv_on   = (regime != `REGIME_SHUT) && !load_reg;
  wire take      = sample_valid_i && conv_on;
  wire conv_done = take && (avg_cnt_reg + 7'd1 == avg_target);

  always @* begin
    case (avg_sel)
      2'b00:   avg_val = acc_sum[15:0];
      2'b01:   avg_val = acc_sum[18:3];
      2'b10:   avg_val = acc_sum[20:5];
      default: avg_val = acc_sum[21:6];
    endcase
  end

  wire above_upper = $signed(avg_val) > $signed(upper_reg); // [R16]
  wire below_lower = $signed(avg_val) < $signed(lower_reg); // [R16]
  wire rd_cfg  = rd_stb_reg && ptr_reg == `OFF_CONFIG;
  wire rd_meas = rd_stb_reg && ptr_reg == `OFF_MEASURED;
  wire wr_cfg  = wr_stb_reg && ptr_reg == `OFF_CONFIG;
  wire nvm_ptr = (ptr_reg >= `OFF_CONFIG && ptr_reg <= `OFF_USER4 && ptr_reg != `OFF_GATE);
  wire [2:0] cell_idx = (ptr_reg < `OFF_GATE) ? ptr_reg[2:0] - 3'h1 : ptr_reg[2:0] - 3'h2;
  wire prog_go = wr_stb_reg && gate_reg && nvm_ptr && !busy_reg;
  wire [1:0] wr_regime = (wr_data_reg[`BIT_REGIME_HI:`BIT_REGIME_LO] == `REGIME_ALT) ?
                         `REGIME_CONT : wr_data_reg[`BIT_REGIME_HI:`BIT_REGIME_LO]; // [R9]

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      measured_reg   <= `RST_MEASURED;
      cfg_reg        <= RST_CFG[11:2];
      upper_reg      <= `RST_UPPER;
      lower_reg      <= `RST_LOWER;
      gate_reg       <= 1'b0;
      high_reg       <= 1'b0;
      low_reg        <= 1'b0;
      done_reg       <= 1'b0;
      busy_reg       <= 1'b1;
      load_reg       <= 1'b1;
      prog_cnt_reg   <= 16'h0000;
      acc_reg        <= 23'h000000;
      avg_cnt_reg    <= 7'h00;
      conv_enable_o  <= 1'b0;
      cycle_period_o <= 3'h0;
      alert_o        <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
        user_reg[i] <= `RST_USER;
      cell_reg[0] <= `RST_CONFIG; // [R14]
      cell_reg[1] <= `RST_UPPER;
      cell_reg[2] <= `RST_LOWER;
      for (i = 3; i < 7; i = i + 1)
        cell_reg[i] <= `RST_USER;
    end else begin
      conv_enable_o  <= conv_on;
      cycle_period_o <= cfg_reg[`BIT_CYCLE_HI-2:`BIT_CYCLE_LO-2]; // [R10]
      busy_reg       <= load_reg || prog_cnt_reg != 16'h0000 || prog_go; // [R8]
      if (prog_cnt_reg != 16'h0000)
        prog_cnt_reg <= prog_cnt_reg - 16'h0001;
      if (load_reg || gc_stb_reg) begin
        // Reload backed registers from cells, reset result and flags; a general call takes the same path
        load_reg     <= gc_stb_reg;
        measured_reg <= `RST_MEASURED; // [R2]
        cfg_reg      <= cell_reg[0][11:2]; // [R14]
        upper_reg    <= cell_reg[1];
        lower_reg    <= cell_reg[2];
        gate_reg     <= 1'b0;
        high_reg     <= 1'b0;
        low_reg      <= 1'b0;
        done_reg     <= 1'b0;
        acc_reg      <= 23'h000000;
        avg_cnt_reg  <= 7'h00;
        for (i = 0; i < 4; i = i + 1)
          user_reg[i] <= cell_reg[i+3];
      end else begin
        if (take) begin
          acc_reg     <= conv_done ? 23'h000000 : acc_sum;
          avg_cnt_reg <= conv_done ? 7'h00 : avg_cnt_reg + 7'd1;
        end
        if (conv_done) begin
          measured_reg <= avg_val; // [R1]
          if (regime == `REGIME_ONESHOT)
            cfg_reg[`BIT_REGIME_HI-2:`BIT_REGIME_LO-2] <= `REGIME_SHUT; // [R9]
        end
        // Set wins over any read clear in the same cycle
        if (conv_done && above_upper)
          high_reg <= 1'b1; // [R3] [R4]
        else if (therm_mode ? (conv_done && below_lower) : rd_cfg)
          high_reg <= 1'b0; // [R3] [R4] [R12]
        if (therm_mode)
          low_reg <= 1'b0; // [R5]
        else if (conv_done && below_lower)
          low_reg <= 1'b1; // [R5]
        else if (rd_cfg)
          low_reg <= 1'b0; // [R5]
        if (conv_done)
          done_reg <= 1'b1; // [R6]
        else if (rd_cfg || rd_meas)
          done_reg <= 1'b0; // [R6]
        if (wr_stb_reg) begin
          case (ptr_reg)
            `OFF_CONFIG: cfg_reg <= {wr_regime, wr_data_reg[9:2]}; // [R17]
            `OFF_UPPER:  upper_reg <= wr_data_reg;
            `OFF_LOWER:  lower_reg <= wr_data_reg;
            `OFF_GATE:   gate_reg <= wr_data_reg[`BIT_GATE_OPEN]; // [R17]
            `OFF_USER1:  user_reg[0] <= wr_data_reg;
            `OFF_USER2:  user_reg[1] <= wr_data_reg;
            `OFF_USER3:  user_reg[2] <= wr_data_reg;
            `OFF_USER4:  user_reg[3] <= wr_data_reg;
            default:     gate_reg <= gate_reg;
          endcase
          if (wr_cfg) begin
            // Averaging may change: restart the block
            acc_reg     <= 23'h000000;
            avg_cnt_reg <= 7'h00;
          end
        end
        if (prog_go) begin
          prog_cnt_reg <= PROG_CYCLES;
          cell_reg[cell_idx] <= wr_cfg ? (wr_data_reg & `CONFIG_STORE_MASK) : wr_data_reg; // [R15]
        end
      end
      // Alert pin source and level
      alert_o <= (pin_src ? done_reg : (high_reg | low_reg)) ~^ level_high; // [R7] [R13]
    end
  end
endmodule // temp_sensor_register_bank

// ---- rtl/temp_bank_regs.vh ----
// Constants for the temperature sensor register bank
// Behaviour
// [R1] Result register holds latest conversion, 16-bit two's complement, 7.8125 m-degC per LSB.
// [R2] After power-up or general-call reset the result reads 8000h until first conversion.
// [R3] Crossing behaviour: upper flag bit 15 sets above upper threshold, clears on config read.
// [R4] Therm behaviour: upper flag sets above limit, clears only below hysteresis, not on read.
// [R5] Lower flag bit 14 sets below lower threshold, clears on config read, zero in therm.
// [R6] Done flag bit 13 sets on result update, clears on result or config read.
// [R7] Pin source bit 2 selects done flag (1) or excursion flags (0) for alert pin.
// [R8] Busy flag bit 12 is high while nonvolatile cells program or load.
// [R9] Regime bits 11:10: 00 continuous, 01 shutdown, 11 one-shot, 10 acts and reads as 00.
// [R10] Cycle period bits 9:7, reset 100, select standby between conversions.
// [R11] Averaging bits 6:5, reset 01, block-accumulate 1/8/32/64 results before update.
// [R12] Behaviour select bit 4: 1 therm, 0 threshold crossing.
// [R13] Level sense bit 3: alert pin active high when 1, active low when 0.
// [R14] Config resets to 0220h; backed registers reload from reprogrammable cells.
// [R15] Regime upper bit is never stored, so start-up is shutdown or continuous only.
// [R16] Therm behaviour uses upper threshold as limit, lower threshold as hysteresis.
// [R17] Writes to read-only bits are ignored; unused bits 1:0 read zero.
// [R18] Pointer byte follows address byte, is kept for reads; registers go MSB first.
// [R19] General call with second byte 06h reloads all registers to power-up values.
`ifndef TEMP_BANK_REGS_VH
`define TEMP_BANK_REGS_VH

`define OFF_MEASURED      8'h00
`define OFF_CONFIG        8'h01
`define OFF_UPPER         8'h02
`define OFF_LOWER         8'h03
`define OFF_GATE          8'h04
`define OFF_USER1         8'h05
`define OFF_USER2         8'h06
`define OFF_USER3         8'h07
`define OFF_USER4         8'h08
`define OFF_IDENTITY      8'h0F

`define BIT_HIGH_FLAG     15
`define BIT_LOW_FLAG      14
`define BIT_DONE_FLAG     13
`define BIT_BUSY_FLAG     12
`define BIT_REGIME_HI     11
`define BIT_REGIME_LO     10
`define BIT_CYCLE_HI      9
`define BIT_CYCLE_LO      7
`define BIT_AVG_HI        6
`define BIT_AVG_LO        5
`define BIT_THERM         4
`define BIT_LEVEL         3
`define BIT_PINSRC        2
`define BIT_GATE_OPEN     15
`define BIT_GATE_BUSY     14

`define RST_MEASURED      16'h8000
`define RST_CONFIG        16'h0220
`define RST_UPPER         16'h6000
`define RST_LOWER         16'h8000
`define RST_GATE          16'h0000
`define RST_USER          16'h0000
`define CONFIG_STORE_MASK 16'h07FC

`define REGIME_CONT       2'b00
`define REGIME_SHUT       2'b01
`define REGIME_ALT        2'b10
`define REGIME_ONESHOT    2'b11

`define GC_ADDR           7'h00
`define GC_RESET_CMD      8'h06
`define NVM_PROG_CYCLES   16'h0010

`endif

// ---- rtl/sync_two_ff.v ----
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module sync_two_ff #(
  parameter RESET_VAL = 1'b1
) (
  input  wire sys_clk_i,
  input  wire rst_b_i,
  input  wire async_i,
  output reg  sync_o
);
  reg meta_reg;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RESET_VAL;
      sync_o   <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule // sync_two_ff

// ---- bench/bus_master_model.sv ----
// Two-wire bus master model driving the sensor bank pins
`timescale 1ns/1ps
module bus_master_model #(
  parameter [6:0] ADDR = 7'h48
) (
  input  wire clk_i,
  input  wire sda_line_i,
  output reg  scl_o,
  output reg  sda_o
);
  integer k;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Pins move only on clock edges; a bit is 16 clocks
  task drv(input c, input d, input integer n);
    begin
      scl_o <= c;
      sda_o <= d;
      repeat (n) @(posedge clk_i);
    end
  endtask
  // Data set mid-low, sampled mid-high
  task bit_x(input b, output r);
    begin
      drv(1'b0, sda_o, 4);
      drv(1'b0, b, 4);
      drv(1'b1, b, 4);
      r = sda_line_i;
      drv(1'b1, b, 4);
    end
  endtask
  task start;
    begin
      drv(1'b0, 1'b1, 4);
      drv(1'b1, 1'b1, 4);
      drv(1'b1, 1'b0, 4);
    end
  endtask
  task stop;
    begin
      drv(1'b0, 1'b0, 4);
      drv(1'b1, 1'b0, 4);
      drv(1'b1, 1'b1, 8);
    end
  endtask
  task wbyte(input [7:0] d, output a);
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_x(d[k], r);
      bit_x(1'b1, r);
      a = ~r;
    end
  endtask
  task rbyte(input nack, output [7:0] d);
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_x(1'b1, d[k]);
      bit_x(nack, r);
    end
  endtask
  task wr_reg(input [6:0] adr, input [7:0] p, input [15:0] d, output ok);
    reg [3:0] a;
    begin
      start;
      wbyte({adr, 1'b0}, a[0]);
      wbyte(p, a[1]);
      wbyte(d[15:8], a[2]);
      wbyte(d[7:0], a[3]);
      stop;
      ok = &a;
    end
  endtask
  // Pointer is written, then a repeated start reads the word
  task rd_reg(input [7:0] p, output [15:0] d);
    reg a;
    begin
      start;
      wbyte({ADDR, 1'b0}, a);
      wbyte(p, a);
      start;
      wbyte({ADDR, 1'b1}, a);
      rbyte(1'b0, d[15:8]);
      rbyte(1'b1, d[7:0]);
      stop;
    end
  endtask
  task gcall;
    reg a;
    begin
      start;
      wbyte(8'h00, a);
      wbyte(8'h06, a);
      stop;
    end
  endtask
endmodule // bus_master_model

// ---- bench/temp_bank_asserts.sv ----
// Pin-level temporal checks of the sensor bank
`timescale 1ns/1ps
module temp_bank_checker (
  input wire        sys_clk_i,
  input wire        rst_b_i,
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_b_o,
  input wire        sample_valid_i,
  input wire [15:0] sample_data_i,
  input wire        conv_enable_o,
  input wire [2:0]  cycle_period_o,
  input wire        alert_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_sda_low;
    sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda drive not low");
  // Drive may only move while the clock line is low
  property p_oe_scl;
    $changed(sda_oe_b_o) |-> !scl_i;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
  property p_ack_hold;
    $fell(sda_oe_b_o) |-> !sda_oe_b_o [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
  property p_release;
    $fell(sda_oe_b_o) |-> ##[1:300] sda_oe_b_o;
  endproperty
  a_release: assert property (p_release) else $error("sda held too long");
  property p_alert_cause;
    $changed(alert_o) |-> !scl_i || $past(sample_valid_i, 1) || $past(sample_valid_i, 2);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert moved alone");
  property p_conv_cause;
    $changed(conv_enable_o) |-> !scl_i || !$past(rst_b_i, 3) || $past(sample_valid_i, 1)
      || $past(sample_valid_i, 2);
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("enable moved alone");
  property p_cycle_cause;
    $changed(cycle_period_o) |-> !scl_i || !$past(rst_b_i, 3);
  endproperty
  a_cycle_cause: assert property (p_cycle_cause) else $error("period moved alone");
  property p_power_up;
    $rose(rst_b_i) |-> ##[1:3] (cycle_period_o == 3'h4 && conv_enable_o && alert_o);
  endproperty
  a_power_up: assert property (p_power_up) else $error("bad start-up state");
endmodule // temp_bank_checker
bind temp_sensor_register_bank temp_bank_checker u_chk (
  .sys_clk_i      (sys_clk_i),
  .rst_b_i        (rst_b_i),
  .scl_i          (scl_i),
  .sda_i          (sda_i),
  .sda_o          (sda_o),
  .sda_oe_b_o     (sda_oe_b_o),
  .sample_valid_i (sample_valid_i),
  .sample_data_i  (sample_data_i),
  .conv_enable_o  (conv_enable_o),
  .cycle_period_o (cycle_period_o),
  .alert_o        (alert_o)
);

// ---- bench/testbench.sv ----
// Self-checking bench of the temperature sensor register bank
`timescale 1ns/1ps
module testbench;
  localparam [15:0] ID_VAL = 16'h3C96; // Arbitrary identity value
  reg         sys_clk_i;
  reg         rst_b_i;
  reg         sample_valid_i;
  reg  [15:0] sample_data_i;
  wire        scl;
  wire        sda_m;
  wire        sda_d;
  wire        sda_oe_b;
  wire        sda_line;
  wire        conv_en;
  wire [2:0]  cyc;
  wire        alert;
  reg  [15:0] v;
  reg         ok;
  integer     i;
  integer     err_count;
  integer     n_checks;
  // Pulled-up line, low while the bank drives
  assign sda_line = sda_m & (sda_oe_b | sda_d);
  bus_master_model master (.clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_m));
  // Long program time so busy is seen by a read
  temp_sensor_register_bank #(.IDENTITY(ID_VAL), .PROG_CYCLES(16'h0400)) DUT (
    .sys_clk_i      (sys_clk_i),
    .rst_b_i        (rst_b_i),
    .scl_i          (scl),
    .sda_i          (sda_line),
    .sda_o          (sda_d),
    .sda_oe_b_o     (sda_oe_b),
    .sample_valid_i (sample_valid_i),
    .sample_data_i  (sample_data_i),
    .conv_enable_o  (conv_en),
    .cycle_period_o (cyc),
    .alert_o        (alert)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        err_count = err_count + 1;
      end
    end
  endtask
  task chkb(input b, input e);
    chk({15'h0000, b}, {15'h0000, e});
  endtask
  task rd(input [7:0] p, input [15:0] exp);
    begin
      master.rd_reg(p, v);
      chk(v, exp);
    end
  endtask
  task wr(input [7:0] p, input [15:0] d);
    begin
      master.wr_reg(7'h48, p, d, ok);
      chkb(ok, 1'b1);
    end
  endtask
  task smp(input [15:0] d);
    begin
      @(posedge sys_clk_i);
      sample_valid_i <= 1'b1;
      sample_data_i <= d;
      @(posedge sys_clk_i);
      sample_valid_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
    end
  endtask
  function [15:0] rst_val(input [3:0] p);
    case (p)
      4'h0: rst_val = 16'h8000;
      4'h1: rst_val = 16'h0220;
      4'h2: rst_val = 16'h6000;
      4'h3: rst_val = 16'h8000;
      4'hF: rst_val = ID_VAL;
      default: rst_val = 16'h0000;
    endcase
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    rst_b_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_data_i = 16'h0000;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk({13'h0000, cyc}, 16'h0004);
    for (i = 0; i < 16; i = i + 1)
      rd(i[7:0], rst_val(i[3:0]));
    wr(8'h01, 16'h0800);
    rd(8'h01, 16'h0000);
    chkb(conv_en, 1'b1);
    wr(8'h01, 16'h0400);
    rd(8'h01, 16'h0400);
    chkb(conv_en, 1'b0);
    wr(8'h01, 16'hFFFF);
    rd(8'h01, 16'h0FFC);
    chk({13'h0000, cyc}, 16'h0007);
    wr(8'h02, 16'h0100);
    wr(8'h03, 16'hFF00);
    wr(8'h01, 16'h0000);
    smp(16'h0200);
    chkb(alert, 1'b0);
    rd(8'h01, 16'hA000);
    rd(8'h01, 16'h0000);
    chkb(alert, 1'b1);
    rd(8'h00, 16'h0200);
    wr(8'h01, 16'h0008);
    smp(16'hFE00);
    chkb(alert, 1'b1);
    rd(8'h01, 16'h6008);
    rd(8'h01, 16'h0008);
    wr(8'h01, 16'h0004);
    smp(16'h0000);
    chkb(alert, 1'b0);
    rd(8'h00, 16'h0000);
    chkb(alert, 1'b1);
    wr(8'h01, 16'h0010);
    smp(16'h0200);
    rd(8'h01, 16'hA010);
    rd(8'h01, 16'h8010);
    smp(16'h0000);
    rd(8'h01, 16'hA010);
    smp(16'hFE00);
    rd(8'h01, 16'h2010);
    // Negative block of eight checks the floor of the mean
    wr(8'h01, 16'h0020);
    for (i = 0; i < 8; i = i + 1) begin
      smp(16'hFFF0 + i[15:0]);
      if (i == 6)
        rd(8'h00, 16'hFE00);
    end
    rd(8'h00, 16'hFFF3);
    wr(8'h01, 16'h0C00);
    smp(16'h0040);
    rd(8'h01, 16'h2400);
    chkb(conv_en, 1'b0);
    master.wr_reg(7'h49, 8'h02, 16'h1234, ok);
    chkb(ok, 1'b0);
    rd(8'h02, 16'h0100);
    wr(8'h04, 16'h8000);
    wr(8'h01, 16'h0C28);
    rd(8'h01, 16'h1C28);
    for (i = 0; i < 8 && v[12] !== 1'b0; i = i + 1)
      master.rd_reg(8'h01, v);
    chk(v, 16'h0C28);
    wr(8'h04, 16'h0000);
    master.gcall;
    rd(8'h01, 16'h0428);
    rd(8'h02, 16'h6000);
    rd(8'h00, 16'h8000);
    close_out;
  end
endmodule // testbench
